//--- hw/tag_memory_command_handler.sv
// Command interpreter for the tag memory, with an AHB-Lite control port
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "tag_cmd_consts.svh"
module tag_memory_command_handler #(
    parameter int         PROG_CYCLES = `PROG_CYCLES,
    parameter logic [63:0] UID        = 64'h0123_4567_89AB_CDEF, // Arbitrary value
    parameter logic [7:0]  REV_CODE   = 8'h5C,                   // Arbitrary value
    parameter logic [7:0]  SPARE_INFO = 8'h00
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        link_clk,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    input  wire logic        rx_end,
    input  wire logic        rx_crc_ok,
    input  wire logic        rx_blk_num,
    output logic [7:0]       tx_data,
    output logic             tx_valid,
    output logic             tx_last,
    output logic             tx_blk_num
);
    tag_cmd_pkg::cmd_state_t state_reg;
    tag_cmd_pkg::link_rx_t   rx_meta;
    tag_cmd_pkg::link_rx_t   rx_sync;
    logic                    link_clk_d;
    logic                    link_rise;
    logic [63:0]             mem_reg  [0:17];
    logic [15:0]             wcnt_reg [0:17];
    logic [7:0]              req_reg  [0:`REQ_MAX-1];
    logic [7:0]              resp_reg [0:`RESP_MAX-1];
    logic [7:0]              exec_resp [0:`RESP_MAX-1];
    logic [3:0]              req_len_reg;
    logic [3:0]              resp_len_reg;
    logic [3:0]              exec_len;
    logic                    exec_silent;
    logic                    exec_prog;
    logic [63:0]             exec_data;
    logic [4:0]              wr_blk_reg;
    logic [63:0]             wr_data_reg;
    logic [31:0]             prog_cnt_reg;
    logic                    active_reg;
    logic [15:0]             req_count_reg;
    logic [7:0]              last_err_reg;
    logic                    ph_write_reg;
    logic                    ph_read_reg;
    logic [31:0]             ph_addr_reg;

    // Two-flop synchroniser; link_rise looks only at the second stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_meta    <= '0;
            rx_sync    <= '0;
            link_clk_d <= 1'b0;
        end else begin
            rx_meta    <= {link_clk, rx_data, rx_valid, rx_end, rx_crc_ok, rx_blk_num};
            rx_sync    <= rx_meta;
            link_clk_d <= rx_sync.clk;
        end
    end
    assign link_rise = rx_sync.clk & ~link_clk_d;

    // Request decode, reply build and write-buffer masking
    logic [7:0] cmd;
    logic [7:0] bnum;
    logic [4:0] b;
    logic       bad_blk;
    logic [63:0] ctrl_blk;
    logic [17:0] lock_bits;
    logic       blk_locked;
    logic       fam_locked;
    logic       eprom;
    always_comb begin
        cmd        = req_reg[0];
        bnum       = req_reg[1];
        b          = bnum[4:0];
        bad_blk    = (bnum > `LAST_BLOCK);
        ctrl_blk   = mem_reg[`CTRL_BLOCK];
        lock_bits  = ctrl_blk[17:0];
        blk_locked = !bad_blk && lock_bits[b];
        fam_locked = (ctrl_blk[8*`FAMILY_LOCK_BYTE +: 8] == `FAMILY_LOCKED);
        eprom      = !bad_blk && !b[4] && ctrl_blk[8*`EPROM_BYTE + b[3:2]];
        for (int i = 0; i < `RESP_MAX; i++) exec_resp[i] = 8'h00;
        exec_len    = 4'h1;
        exec_silent = 1'b0;
        exec_prog   = 1'b0;
        exec_data   = mem_reg[b];
        exec_resp[0] = `IND_OK;
        if ((cmd == `CMD_READ_BLOCK || cmd == `CMD_SECURE_READ || cmd == `CMD_CUSTOM_READ ||
             cmd == `CMD_WRITE_BLOCK || cmd == `CMD_LOCK_BLOCK) && bad_blk) begin
            exec_resp[0] = `IND_FAIL;
            exec_resp[1] = `ERR_BAD_BLOCK;
            exec_len     = 4'h2;
        end else if (cmd == `CMD_SYS_INFO) begin
            exec_resp[1] = `INFO_FLAGS;
            for (int i = 0; i < 8; i++) exec_resp[2+i] = UID[8*i +: 8];
            exec_resp[10] = SPARE_INFO;
            exec_resp[11] = mem_reg[`FAMILY_BLOCK][8*`FAMILY_BYTE +: 8];
            exec_resp[12] = `BLOCK_COUNT;
            exec_resp[13] = `BLOCK_SIZE_CODE;
            exec_resp[14] = REV_CODE;
            exec_len      = 4'hF;
        end else if (cmd == `CMD_READ_ID) begin
            for (int i = 0; i < 8; i++) exec_resp[1+i] = UID[8*i +: 8];
            exec_len = 4'h9;
        end else if (cmd == `CMD_READ_BLOCK) begin
            for (int i = 0; i < 8; i++) exec_resp[1+i] = mem_reg[b][8*i +: 8];
            exec_len = 4'h9;
        end else if (cmd == `CMD_SECURE_READ) begin
            exec_resp[1] = blk_locked ? `SEC_PROTECTED : `SEC_UNPROTECTED;
            for (int i = 0; i < 8; i++) exec_resp[2+i] = mem_reg[b][8*i +: 8];
            exec_len = 4'hA;
        end else if (cmd == `CMD_CUSTOM_READ) begin
            for (int i = 0; i < 8; i++) exec_resp[1+i] = mem_reg[b][8*i +: 8];
            exec_resp[9]  = wcnt_reg[b][7:0];
            exec_resp[10] = wcnt_reg[b][15:8];
            exec_len      = 4'hB;
        end else if (cmd == `CMD_WRITE_BLOCK && req_len_reg == 4'(`REQ_MAX)) begin
            if (blk_locked) begin
                exec_resp[0] = `IND_FAIL;
                exec_resp[1] = `ERR_WRITE_LOCKED;
                exec_len     = 4'h2;
            end else begin
                exec_prog = 1'b1;
                for (int i = 0; i < 8; i++) begin
                    exec_data[8*i +: 8] = eprom ? (req_reg[2+i] & mem_reg[b][8*i +: 8])
                                                : req_reg[2+i];
                end
                // Lock and mode bits only ever set, so a write cannot unlock
                if (b == `CTRL_BLOCK) begin
                    exec_data[31:0] = exec_data[31:0] | ctrl_blk[31:0];
                    if (fam_locked) exec_data[8*`FAMILY_LOCK_BYTE +: 8] = `FAMILY_LOCKED;
                end
                if (b == `FAMILY_BLOCK && fam_locked)
                    exec_data[8*`FAMILY_BYTE +: 8] = mem_reg[b][8*`FAMILY_BYTE +: 8];
            end
        end else if (cmd == `CMD_LOCK_BLOCK && req_len_reg == 4'h2) begin
            if (blk_locked) begin
                exec_resp[0] = `IND_FAIL;
                exec_resp[1] = `ERR_ALREADY_LOCKED;
                exec_len     = 4'h2;
            end else begin
                exec_prog    = 1'b1;
                exec_data    = ctrl_blk;
                exec_data[b] = 1'b1;
            end
        end else if (cmd == `CMD_WRITE_FAMILY && req_len_reg == 4'h2) begin
            if (fam_locked) begin
                exec_resp[0] = `IND_FAIL;
                exec_resp[1] = `ERR_WRITE_LOCKED;
                exec_len     = 4'h2;
            end else begin
                exec_prog = 1'b1;
                exec_data = mem_reg[`FAMILY_BLOCK];
                exec_data[8*`FAMILY_BYTE +: 8] = bnum;
            end
        end else if (cmd == `CMD_LOCK_FAMILY) begin
            if (fam_locked) begin
                exec_resp[0] = `IND_FAIL;
                exec_resp[1] = `ERR_ALREADY_LOCKED;
                exec_len     = 4'h2;
            end else begin
                exec_prog = 1'b1;
                exec_data = ctrl_blk;
                exec_data[8*`FAMILY_LOCK_BYTE +: 8] = `FAMILY_LOCKED;
            end
        end else begin
            exec_silent = 1'b1;
        end
    end

    logic [4:0] exec_blk;
    assign exec_blk = (cmd == `CMD_LOCK_BLOCK || cmd == `CMD_LOCK_FAMILY) ? `CTRL_BLOCK :
                      (cmd == `CMD_WRITE_FAMILY) ? `FAMILY_BLOCK : b;

    // Command sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg    <= tag_cmd_pkg::ST_IDLE;
            req_len_reg  <= 4'h0;
            resp_len_reg <= 4'h0;
            prog_cnt_reg <= 32'h0000_0000;
            wr_blk_reg   <= 5'h00;
            wr_data_reg  <= 64'h0;
            tx_blk_num   <= 1'b0;
            last_err_reg <= 8'h00;
            for (int i = 0; i < `REQ_MAX; i++) req_reg[i] <= 8'h00;
            for (int i = 0; i < `RESP_MAX; i++) resp_reg[i] <= 8'h00;
        end else if (link_rise || state_reg == tag_cmd_pkg::ST_EXEC || state_reg == tag_cmd_pkg::ST_PROG) begin
            case (state_reg)
                tag_cmd_pkg::ST_IDLE, tag_cmd_pkg::ST_RX: begin
                    if (rx_sync.valid && req_len_reg < 4'(`REQ_MAX)) begin
                        req_reg[req_len_reg] <= rx_sync.data;
                        req_len_reg          <= req_len_reg + 4'h1;
                        state_reg            <= tag_cmd_pkg::ST_RX;
                    end
                    if (rx_sync.frame_end) begin
                        tx_blk_num <= rx_sync.blk_num;
                        state_reg  <= (rx_sync.crc_ok && active_reg && req_len_reg != 4'h0) ?
                                      tag_cmd_pkg::ST_EXEC : tag_cmd_pkg::ST_IDLE;
                        if (!(rx_sync.crc_ok && active_reg)) req_len_reg <= 4'h0;
                    end
                end
                tag_cmd_pkg::ST_EXEC: begin
                    for (int i = 0; i < `RESP_MAX; i++) resp_reg[i] <= exec_resp[i];
                    resp_len_reg <= exec_len;
                    wr_blk_reg   <= exec_blk;
                    wr_data_reg  <= exec_data;
                    prog_cnt_reg <= 32'(PROG_CYCLES);
                    req_len_reg  <= 4'h0;
                    last_err_reg <= (exec_len == 4'h2) ? exec_resp[1] : 8'h00;
                    state_reg    <= exec_silent ? tag_cmd_pkg::ST_IDLE :
                                    exec_prog ? tag_cmd_pkg::ST_PROG : tag_cmd_pkg::ST_TX;
                end
                tag_cmd_pkg::ST_PROG: begin
                    prog_cnt_reg <= prog_cnt_reg - 32'h1;
                    if (prog_cnt_reg == 32'h1) state_reg <= tag_cmd_pkg::ST_TX;
                end
                tag_cmd_pkg::ST_TX: begin
                    // Shift register keeps tx_data straight from a flop
                    for (int i = 0; i < `RESP_MAX - 1; i++) resp_reg[i] <= resp_reg[i+1];
                    resp_len_reg <= resp_len_reg - 4'h1;
                    if (resp_len_reg == 4'h1) state_reg <= tag_cmd_pkg::ST_IDLE;
                end
                default: state_reg <= tag_cmd_pkg::ST_IDLE;
            endcase
        end
    end

    // Nonvolatile array; committed at the last programming cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 18; i++) begin
                mem_reg[i]  <= 64'h0;
                wcnt_reg[i] <= 16'h0000;
            end
        end else if (state_reg == tag_cmd_pkg::ST_PROG && prog_cnt_reg == 32'h1) begin
            mem_reg[wr_blk_reg]  <= wr_data_reg;
            wcnt_reg[wr_blk_reg] <= wcnt_reg[wr_blk_reg] + 16'h1;
        end
    end

    // Reply handed to the framer; a byte is taken at each link clock rise
    assign tx_valid = (state_reg == tag_cmd_pkg::ST_TX);
    assign tx_last  = tx_valid && (resp_len_reg == 4'h1);
    assign tx_data  = resp_reg[0];

    // AHB-Lite slave, zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_write_reg <= 1'b0;
            ph_read_reg  <= 1'b0;
            ph_addr_reg  <= 32'h0000_0000;
        end else if (hready) begin
            ph_write_reg <= hsel && htrans[1] && hwrite;
            ph_read_reg  <= hsel && htrans[1] && !hwrite;
            ph_addr_reg  <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_reg <= 1'b0;
        end else if (ph_write_reg && ph_addr_reg == `REG_CTRL) begin
            active_reg <= hwdata[`CTRL_ACTIVE_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_count_reg <= 16'h0000;
        end else if (state_reg == tag_cmd_pkg::ST_EXEC) begin
            req_count_reg <= req_count_reg + 16'h1;
        end
    end

    always_comb begin
        hrdata = 32'h0000_0000;
        if (!ph_read_reg) begin
            hrdata = 32'h0000_0000;
        end else if (ph_addr_reg == `REG_CTRL) begin
            hrdata = {31'h0, active_reg};
        end else if (ph_addr_reg == `REG_STATUS) begin
            hrdata = {16'h0, last_err_reg, 5'h0, state_reg};
        end else if (ph_addr_reg == `REG_REQ_COUNT) begin
            hrdata = {16'h0, req_count_reg};
        end else if (ph_addr_reg == `REG_REVISION) begin
            hrdata = {24'h0, REV_CODE};
        end
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    a_prog_full_time: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(state_reg == tag_cmd_pkg::ST_PROG) |-> prog_cnt_reg == 32'(PROG_CYCLES))
        else $error("programming started with a wrong count");
    a_no_tx_in_prog: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg == tag_cmd_pkg::ST_PROG && prog_cnt_reg > 32'h1 |=> !tx_valid)
        else $error("reply sent before programming ended");
    a_silent_unknown: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg == tag_cmd_pkg::ST_EXEC && exec_silent |=> state_reg == tag_cmd_pkg::ST_IDLE)
        else $error("unknown command not ignored");
    a_inactive_idle: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg == tag_cmd_pkg::ST_RX && link_rise && rx_sync.frame_end && !(active_reg && rx_sync.crc_ok)
        |=> state_reg == tag_cmd_pkg::ST_IDLE)
        else $error("request processed while inactive or with a bad checksum");
    a_bad_block_err: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg == tag_cmd_pkg::ST_EXEC && cmd == `CMD_READ_BLOCK && bnum > `LAST_BLOCK
        |=> resp_reg[0] == `IND_FAIL && resp_reg[1] == `ERR_BAD_BLOCK && resp_len_reg == 4'h2)
        else $error("invalid block not reported");
    a_write_ok_len: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(state_reg == tag_cmd_pkg::ST_PROG) |-> resp_len_reg == 4'h1 && resp_reg[0] == `IND_OK)
        else $error("write reply is not a single ok byte");
    a_sysinfo_len: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg == tag_cmd_pkg::ST_EXEC && cmd == `CMD_SYS_INFO
        |=> resp_len_reg == 4'hF && resp_reg[1] == `INFO_FLAGS && resp_reg[14] == REV_CODE)
        else $error("system information reply malformed");
    a_uid_order: assert property (@(posedge hclk) disable iff (!hresetn)
        state_reg == tag_cmd_pkg::ST_EXEC && cmd == `CMD_READ_ID
        |=> resp_reg[1] == UID[7:0] && resp_reg[8] == UID[63:56])
        else $error("identifier byte order wrong");
    a_blk_num_held: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_valid |=> $stable(tx_blk_num))
        else $error("reply block number changed during reply");
    c_write: cover property (@(posedge hclk) disable iff (!hresetn)
        state_reg == tag_cmd_pkg::ST_PROG ##1 state_reg == tag_cmd_pkg::ST_TX);
    c_read: cover property (@(posedge hclk) disable iff (!hresetn)
        state_reg == tag_cmd_pkg::ST_EXEC && cmd == `CMD_READ_BLOCK && !bad_blk);
    c_error: cover property (@(posedge hclk) disable iff (!hresetn) tx_valid && tx_data == `IND_FAIL);
endmodule

//--- hw/tag_cmd_consts.svh
// Command codes, reply codes, memory layout, register map and timing of the tag command handler
`ifndef TAG_CMD_CONSTS_SVH
`define TAG_CMD_CONSTS_SVH
`define CMD_READ_BLOCK      8'h20
`define CMD_WRITE_BLOCK     8'h21
`define CMD_LOCK_BLOCK      8'h22
`define CMD_WRITE_FAMILY    8'h27
`define CMD_LOCK_FAMILY     8'h28
`define CMD_SYS_INFO        8'h2B
`define CMD_READ_ID         8'h30
`define CMD_CUSTOM_READ     8'hA4
`define CMD_SECURE_READ     8'hB0
`define IND_OK              8'h00
`define IND_FAIL            8'h01
`define ERR_BAD_BLOCK       8'h10
`define ERR_ALREADY_LOCKED  8'h11
`define ERR_WRITE_LOCKED    8'h12
`define INFO_FLAGS          8'h0F
`define BLOCK_COUNT         8'h12
`define BLOCK_SIZE_CODE     8'h07
`define SEC_UNPROTECTED     8'h00
`define SEC_PROTECTED       8'h01
`define LAST_BLOCK          8'h11
`define FAMILY_BLOCK        5'h10
`define CTRL_BLOCK          5'h11
`define FAMILY_BYTE         3
`define EPROM_BYTE          3
`define FAMILY_LOCK_BYTE    4
`define FAMILY_LOCKED       8'hAA
`define REQ_MAX             10
`define RESP_MAX            15
`define REG_CTRL            32'h0000_0000
`define REG_STATUS          32'h0000_0004
`define REG_REQ_COUNT       32'h0000_0008
`define REG_REVISION        32'h0000_000C
`define CTRL_ACTIVE_BIT     0
`define TPROG_NS            10000000
`define HCLK_NS             25
`define PROG_CYCLES         ((`TPROG_NS + `HCLK_NS - 1) / `HCLK_NS)
`endif

//--- hw/tag_cmd_pkg.sv
// Types shared by the tag command handler
package tag_cmd_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_EXEC, ST_PROG, ST_TX} cmd_state_t;
    typedef struct packed {
        logic       clk;
        logic [7:0] data;
        logic       valid;
        logic       frame_end;
        logic       crc_ok;
        logic       blk_num;
    } link_rx_t;
endpackage

//--- tb/rf_reader_model.sv
// Reader model: sends request frames and clocks reply bytes out of the tag
`timescale 1ns/1ps
module rf_reader_model (
    output logic            link_clk,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    output logic            rx_end,
    output logic            rx_crc_ok,
    output logic            rx_blk_num,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    input  wire logic       tx_last,
    input  wire logic       tx_blk_num
);
    logic [7:0] rsp [0:15];
    int         rsp_len;
    int         waited;
    logic       blk_seen;
    logic       last_seen;
    initial begin
        link_clk = 1'b0;
        rx_data = 8'h00;
        rx_valid = 1'b0;
        rx_end = 1'b0;
        rx_crc_ok = 1'b0;
        rx_blk_num = 1'b0;
    end
    // Clock stands still between frames; inputs move on the fall, on an hclk edge
    task automatic pulse();
        #100 link_clk <= 1'b1;
        #100 link_clk <= 1'b0;
    endtask
    task automatic send(input logic [79:0] req, input int n, input logic blk, input logic crc);
        for (int i = 0; i < n; i++) begin
            rx_data <= req[(n - 1 - i) * 8 +: 8];
            rx_valid <= 1'b1;
            pulse();
        end
        rx_valid <= 1'b0;
        rx_end <= 1'b1;
        rx_crc_ok <= crc;
        rx_blk_num <= blk;
        pulse();
        rx_end <= 1'b0;
        rx_crc_ok <= ~crc;
        // Stale byte must not look like the last one sent
        rx_data <= ~rx_data;
        rsp_len = 0;
        waited = 0;
        // Reply sampled mid-cycle, away from the edges that move it
        #12.5;
        while (tx_valid !== 1'b1 && waited < 200) begin
            #25 waited++;
        end
        while (tx_valid === 1'b1 && rsp_len < 16) begin
            rsp[rsp_len] = tx_data;
            blk_seen = tx_blk_num;
            last_seen = tx_last;
            rsp_len++;
            #87.5 link_clk <= 1'b1;
            #100 link_clk <= 1'b0;
            #112.5;
        end
        #12.5;
    endtask
endmodule

//--- tb/tag_memory_command_handler_tb.sv
// Self-checking bench for the tag command handler
`timescale 1ns/1ps
`include "tag_cmd_consts.svh"
module tag_memory_command_handler_tb;
    localparam int          PROG   = 20;
    localparam logic [63:0] UID    = 64'h0123_4567_89AB_CDEF; // Arbitrary value
    localparam logic [63:0] UID_LE = 64'hEFCD_AB89_6745_2301;
    localparam logic [7:0]  REV    = 8'h3D;                   // Arbitrary value
    localparam logic [63:0] D      = 64'h1122_3344_5566_7788;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, blk;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  rx_data, tx_data;
    logic        link_clk, rx_valid, rx_end, rx_crc_ok, rx_blk_num, tx_valid, tx_last, tx_blk_num;
    int          errors, checks_done;
    tag_memory_command_handler #(.PROG_CYCLES(PROG), .UID(UID), .REV_CODE(REV), .SPARE_INFO(8'h00)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .link_clk(link_clk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end),
        .rx_crc_ok(rx_crc_ok), .rx_blk_num(rx_blk_num), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_last(tx_last), .tx_blk_num(tx_blk_num));
    rf_reader_model rf (.link_clk(link_clk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end),
        .rx_crc_ok(rx_crc_ok), .rx_blk_num(rx_blk_num), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_last(tx_last), .tx_blk_num(tx_blk_num));
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Ready and read data looked at mid-cycle: they hold these values at the next rise
    task automatic wait_rdy();
        int t;
        t = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1) begin
            t++;
            if (t > 50) begin
                errors++;
                wrap_up();
            end
            @(negedge hclk);
        end
        rd = hrdata;
        @(posedge hclk);
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
    endtask
    // Expected reply bytes are packed first byte highest
    task automatic xact(input logic [79:0] req, input int n, input logic [119:0] exp, input int en,
                        input logic crc = 1'b1);
        blk = ~blk;
        rf.send(req, n, blk, crc);
        check(32'(rf.rsp_len), 32'(en));
        for (int i = 0; i < en && i < rf.rsp_len; i++) begin
            check({24'h0, rf.rsp[i]}, {24'h0, exp[(en - 1 - i) * 8 +: 8]});
        end
        if (en > 0) begin
            check({31'h0, rf.blk_seen}, {31'h0, blk});
            check({31'h0, rf.last_seen}, 32'h1);
        end
        $display("request %h done", req);
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        errors = 0;
        checks_done = 0;
        blk = 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        xact(16'h2000, 2, 0, 0);
        ahb(1'b1, `REG_CTRL, 32'h1);
        ahb(1'b0, `REG_CTRL, 32'h0);
        check(rd, 32'h1);
        ahb(1'b0, `REG_REVISION, 32'h0);
        check(rd, {24'h0, REV});
        ahb(1'b0, 32'h0000_0010, 32'h0);
        check(rd, 32'h0);
        check({31'h0, hresp}, 32'h0);
        xact(8'h2B, 1, {16'h000F, UID_LE, 32'h0000_1207, REV}, 15);
        xact({16'h2105, D}, 10, 8'h00, 1);
        check(32'(rf.waited > PROG - 4), 32'h1);
        xact({16'h2105, 64'hFFFF_FFFF_FFFF_FFFF}, 10, 0, 0, 1'b0);
        xact(16'h2005, 2, {8'h00, D}, 9);
        xact(16'h2012, 2, 16'h0110, 2);
        xact(16'h2011, 2, 72'h0, 9);
        xact(8'h55, 1, 0, 0);
        xact(8'h30, 1, {8'h00, UID_LE}, 9);
        xact(16'hA405, 2, {8'h00, D, 16'h0100}, 11);
        xact(16'h2205, 2, 8'h00, 1);
        check(32'(rf.waited > PROG - 4), 32'h1);
        xact(16'hB005, 2, {16'h0001, D}, 10);
        xact({16'h2105, D}, 10, 16'h0112, 2);
        xact(16'h2205, 2, 16'h0111, 2);
        xact(16'h275A, 2, 8'h00, 1);
        xact(16'h2010, 2, {8'h00, 64'h0000_005A_0000_0000}, 9);
        xact({16'h2100, 64'h0F0F_0F0F_0F0F_0F0F}, 10, 8'h00, 1);
        // Locks block 1, EPROM mode on page 0, family code locked
        xact({16'h2111, 64'h0200_0001_AA00_0000}, 10, 8'h00, 1);
        xact({16'h2100, 64'h3C3C_3C3C_3C3C_3C3C}, 10, 8'h00, 1);
        xact(16'h2000, 2, {8'h00, 64'h0C0C_0C0C_0C0C_0C0C}, 9);
        xact(16'hB001, 2, {16'h0001, 64'h0}, 10);
        xact(16'h2733, 2, 16'h0112, 2);
        xact(8'h28, 1, 16'h0111, 2);
        ahb(1'b0, `REG_STATUS, 32'h0);
        check(rd, 32'h0000_1100);
        xact({16'h2110, 64'h0000_0077_0000_0000}, 10, 8'h00, 1);
        xact(16'h2010, 2, {8'h00, 64'h0000_005A_0000_0000}, 9);
        ahb(1'b0, `REG_REQ_COUNT, 32'h0);
        check(rd, 32'h0000_0017);
        wrap_up();
    end
endmodule
